// *** rtl/adcf_frame.sv ***
// Serial frame engine, conversion control and alarm bank of the converter
`timescale 1ns/1ps
`default_nettype none
`include "adcf_params.svh"
module adcf_frame import adcf_pkg::*;
#(
  parameter int NCH = 8,
  parameter int NCH_W = $clog2(NCH)
)
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic alarm_o,
  input wire logic [1:0] out_fmt_i,
  output logic conv_start_o,
  output logic [NCH_W-1:0] conv_chan_o,
  input wire logic [`ADCF_CODE_BITS-1:0] conv_code_i,
  input wire logic conv_done_i,
  output logic busy_o,
  output logic [`ADCF_CODE_BITS-1:0] result_o,
  output logic [`ADCF_CFG_BITS-1:0] cfg_word_o,
  input wire logic [NCH*`ADCF_CODE_BITS-1:0] hi_thr_i,
  input wire logic [NCH*`ADCF_HYS_BITS-1:0] hi_hys_i,
  input wire logic [NCH*`ADCF_CODE_BITS-1:0] lo_thr_i,
  input wire logic [NCH*`ADCF_HYS_BITS-1:0] lo_hys_i,
  input wire logic [NCH-1:0] trip_rd_i,
  output logic [NCH-1:0] hi_act_o,
  output logic [NCH-1:0] lo_act_o,
  output logic [NCH-1:0] hi_trip_o,
  output logic [NCH-1:0] lo_trip_o
);
  // ==========================================================
  // Elaboration checks
  // Tripped byte in the output frame holds one bit per channel
  generate
    if (NCH < 2 || NCH > 8 || NCH_W != $clog2(NCH))
    begin : g_bad_nch
      $error("channel count must be 2 to 8 with matching index width");
    end
  endgenerate

  // ==========================================================
  // Declarations
  adcf_conv_st_t st;
  adcf_conv_st_t next_st;
  logic cs_s;
  logic cs_prev;
  logic cs_fall;
  logic tgl_s;
  logic tgl_prev;
  logic cfg_arrive;
  logic [`ADCF_CFG_BITS-1:0] pend_cfg;
  logic [`ADCF_CFG_BITS-1:0] next_cfg;
  logic [NCH_W-1:0] next_ch;
  logic [1:0] fmt_cur;
  logic [`ADCF_SNAP_BITS-1:0] snap;
  logic [5:0] snap_len;
  logic any_trip;
  logic [7:0] trip_byte;
  logic [5:0] bit_cnt;
  logic [`ADCF_CFG_BITS-1:0] cfg_shift;
  logic [`ADCF_SNAP_BITS-1:0] out_shift;
  logic [5:0] out_left;
  logic [`ADCF_CFG_BITS-1:0] cfg_lnk;
  logic cfg_tgl;
  logic alm_meta;
  logic alm_sync;

  // ==========================================================
  // Crossings into the system clock
  adcf_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .clk_i(sys_clk_i),
    .srst_i(srst_i),
    .d_i(cs_n_i),
    .q_o(cs_s)
  );

  adcf_sync #(.RST_VAL(1'b0)) u_cfg_sync (
    .clk_i(sys_clk_i),
    .srst_i(srst_i),
    .d_i(cfg_tgl),
    .q_o(tgl_s)
  );

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cs_prev <= 1'b1;
      tgl_prev <= 1'b0;
    end
    else
    begin
      cs_prev <= cs_s;
      tgl_prev <= tgl_s;
    end
  end

  assign cs_fall = cs_prev && !cs_s;
  assign cfg_arrive = tgl_s ^ tgl_prev;

  // ==========================================================
  // Configuration staging
  // A word landing in the frame-start cycle still counts for that start
  always_comb
  begin
    next_cfg = cfg_arrive ? cfg_lnk : pend_cfg;
    next_ch = conv_chan_o;
    if (next_cfg[`ADCF_CFG_WR_BIT])
      next_ch = next_cfg[`ADCF_CFG_CH_LSB +: NCH_W];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      pend_cfg <= `ADCF_CFG_RST;
    else if (cfg_arrive)
      pend_cfg <= cfg_lnk;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cfg_word_o <= `ADCF_CFG_RST;
      conv_chan_o <= '0;
      fmt_cur <= ADCF_FMT_16;
    end
    else if (cs_fall)
    begin
      cfg_word_o <= next_cfg;
      conv_chan_o <= next_ch;
      fmt_cur <= out_fmt_i;
    end
  end

  // ==========================================================
  // Conversion sequencer
  always_comb
  begin
    next_st = st;
    case (st)
      ADCF_IDLE:
        if (cs_fall)
          next_st = ADCF_CONV;
      ADCF_CONV:
        if (conv_done_i)
          next_st = ADCF_DONE;
      ADCF_DONE:
        if (cs_fall)
          next_st = ADCF_CONV;
      default:
        next_st = ADCF_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      st <= ADCF_IDLE;
    else
      st <= next_st;
  end

  // Start strobe only from a chip select fall, so a high select stays idle
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      conv_start_o <= 1'b0;
    else
      conv_start_o <= cs_fall && st != ADCF_CONV;
  end

  assign busy_o = (st == ADCF_CONV);

  // ==========================================================
  // Result capture and output frame snapshot
  // Code is kept unsigned as the core delivers it; one step is span/65536
  always_comb
  begin
    trip_byte = '0;
    trip_byte[NCH-1:0] = hi_trip_o | lo_trip_o;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      result_o <= '0;
      snap <= '0;
      snap_len <= `ADCF_LEN_FMT16;
    end
    else if (st == ADCF_CONV && conv_done_i)
    begin
      result_o <= conv_code_i;
      snap <= {conv_code_i, 8'(conv_chan_o), trip_byte};
      case (fmt_cur)
        ADCF_FMT_16: snap_len <= `ADCF_LEN_FMT16;
        ADCF_FMT_24: snap_len <= `ADCF_LEN_FMT24;
        default: snap_len <= `ADCF_LEN_FMT32;
      endcase
    end
  end

  // ==========================================================
  // Alarm bank, one high and low alarm unit per channel
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_alarm
      adcf_alarm #(.CW(`ADCF_CODE_BITS), .HW(`ADCF_HYS_BITS)) u_alarm (
        .clk_i(sys_clk_i),
        .srst_i(srst_i),
        .eval_i(st == ADCF_CONV && conv_done_i && conv_chan_o == NCH_W'(gi)),
        .code_i(conv_code_i),
        .hi_thr_i(hi_thr_i[gi*`ADCF_CODE_BITS +: `ADCF_CODE_BITS]),
        .hi_hys_i(hi_hys_i[gi*`ADCF_HYS_BITS +: `ADCF_HYS_BITS]),
        .lo_thr_i(lo_thr_i[gi*`ADCF_CODE_BITS +: `ADCF_CODE_BITS]),
        .lo_hys_i(lo_hys_i[gi*`ADCF_HYS_BITS +: `ADCF_HYS_BITS]),
        .trip_rd_i(trip_rd_i[gi]),
        .hi_act_o(hi_act_o[gi]),
        .lo_act_o(lo_act_o[gi]),
        .hi_trip_o(hi_trip_o[gi]),
        .lo_trip_o(lo_trip_o[gi])
      );
    end
  endgenerate

  assign any_trip = |(hi_trip_o | lo_trip_o);

  // ==========================================================
  // Link side: frame counter and shifters, cleared while select is high
  // Snapshot and length are static from conversion end to the next start,
  // so they are read directly at the 16th edge; this relies on the host
  // never giving that edge before the conversion ends
  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      bit_cnt <= '0;
      cfg_shift <= '0;
    end
    else
    begin
      if (bit_cnt != 6'h3F)
        bit_cnt <= bit_cnt + 6'h01;
      if (bit_cnt < 6'(`ADCF_FRAME_EDGE))
        cfg_shift <= {cfg_shift[`ADCF_CFG_BITS-2:0], sdi_i};
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      sdo_o <= 1'b0;
      out_shift <= '0;
      out_left <= '0;
    end
    else if (bit_cnt == 6'(`ADCF_SDO_LOW_EDGES))
    begin
      sdo_o <= snap[`ADCF_SNAP_BITS-1];
      out_shift <= {snap[`ADCF_SNAP_BITS-2:0], 1'b0};
      out_left <= snap_len - 6'h01;
    end
    else if (bit_cnt > 6'(`ADCF_SDO_LOW_EDGES) && out_left != 6'h00)
    begin
      sdo_o <= out_shift[`ADCF_SNAP_BITS-1];
      out_shift <= {out_shift[`ADCF_SNAP_BITS-2:0], 1'b0};
      out_left <= out_left - 6'h01;
    end
    else
      sdo_o <= 1'b0;
  end

  // Pin is released the moment select rises, without waiting for a clock
  assign sdo_oe_o = !cs_n_i;

  // ==========================================================
  // Link side: word hand-off and alarm pin, kept across frames
  always_ff @(negedge sclk_i or posedge srst_i)
  begin
    if (srst_i)
    begin
      alm_meta <= 1'b0;
      alm_sync <= 1'b0;
    end
    else
    begin
      alm_meta <= any_trip;
      alm_sync <= alm_meta;
    end
  end

  always_ff @(negedge sclk_i or posedge srst_i)
  begin
    if (srst_i)
    begin
      cfg_lnk <= `ADCF_CFG_RST;
      cfg_tgl <= 1'b0;
      alarm_o <= 1'b0;
    end
    else if (!cs_n_i && bit_cnt == 6'(`ADCF_SDO_LOW_EDGES))
    begin
      cfg_lnk <= {cfg_shift[`ADCF_CFG_BITS-2:0], sdi_i};
      cfg_tgl <= !cfg_tgl;
      alarm_o <= alm_sync;
    end
  end

  // ==========================================================
  // Checks
  sequence s_edge16;
    !cs_n_i && bit_cnt == 6'(`ADCF_SDO_LOW_EDGES);
  endsequence

  sequence s_msb_out;
    sdo_o == $past(snap[`ADCF_SNAP_BITS-1]);
  endsequence

  chk_msb_at_16: assert property (@(negedge sclk_i) disable iff (cs_n_i)
    s_edge16 |=> s_msb_out)
    else $error("msb not driven at 16th edge");
  chk_sdo_low_early: assert property (@(negedge sclk_i) disable iff (cs_n_i)
    bit_cnt > 6'h00 && bit_cnt <= 6'(`ADCF_SDO_LOW_EDGES) |-> !sdo_o)
    else $error("serial output not low before 16th edge");
  chk_sdo_tail_low: assert property (@(negedge sclk_i) disable iff (cs_n_i)
    bit_cnt > 6'(`ADCF_SDO_LOW_EDGES) && out_left == 6'h00 |=> !sdo_o)
    else $error("serial output not low after frame");
  chk_alarm_only_16: assert property (@(negedge sclk_i) disable iff (srst_i)
    !(bit_cnt == 6'(`ADCF_SDO_LOW_EDGES) && !cs_n_i) |=> $stable(alarm_o))
    else $error("alarm changed off the 16th edge");
  chk_start_on_fall: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cs_fall && st != ADCF_CONV |=> conv_start_o && conv_chan_o == $past(next_ch))
    else $error("no conversion start at frame start");
  chk_no_idle_start: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !cs_fall |=> !conv_start_o)
    else $error("conversion started without frame");
  chk_cfg_hold_frame: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !cs_fall |=> $stable(cfg_word_o) && $stable(conv_chan_o))
    else $error("configuration changed outside frame start");
endmodule
`default_nettype wire

// *** rtl/adcf_params.svh ***
// Constants of the converter serial frame and alarm block
// What this block does
// - Results leave as unsigned straight-binary codes for every range and channel.
// - One code step is the range span over 65536; codes cover full span.
// - Alarm output is active high and changes only on the 16th falling clock edge.
// - Alarm output is high when any channel has a tripped alarm flag.
// - Every channel has its own high and low thresholds, each with own hysteresis.
// - High alarm sets when the code exceeds high threshold plus hysteresis.
// - High alarm clears when code is at or below threshold minus hysteresis minus 2.
// - Low alarm sets when code is below low threshold minus hysteresis minus 1.
// - Low alarm clears when code is at or above threshold plus hysteresis plus 1.
// - Active flags follow each alarm condition, set at start, cleared at end.
// - Tripped flags set like active flags, stay latched, clear only when read.
// - A falling chip select starts each frame, sampling and starting a conversion unless one is still running.
// - The converted channel is the one configured during the previous frame.
// - While chip select is high the interface stays idle.
// - All serial transfers are timed on falling serial clock edges.
// - One input bit is taken on each of the first 16 falling edges.
// - Configuration received in a frame takes effect at the next chip select fall.
// - Serial output is driven while chip select is low, released when high.
// - Serial output stays low through the first 15 falling edges.
// - The result MSB appears at the 16th falling edge, then one bit per edge.
// - After the whole output frame the serial output stays low.
// - Output frame length follows a configurable output format setting.
// - Input is ignored after the 16th edge; host samples each bit one edge later.
`ifndef ADCF_PARAMS_SVH
`define ADCF_PARAMS_SVH

// ==========================================================
// Frame layout
`define ADCF_CFG_BITS 16
`define ADCF_FRAME_EDGE 16
`define ADCF_SDO_LOW_EDGES 15
`define ADCF_CFG_WR_BIT 15
`define ADCF_CFG_CH_LSB 8
`define ADCF_CFG_RST 16'h0000
`define ADCF_SNAP_BITS 32

// ==========================================================
// Codes, alarms and output formats
`define ADCF_CODE_BITS 16
`define ADCF_CODE_SPAN 65536
`define ADCF_HYS_BITS 8
`define ADCF_HI_CLR_OFS 2
`define ADCF_LO_SET_OFS 1
`define ADCF_LO_CLR_OFS 1
`define ADCF_LEN_FMT16 6'h10
`define ADCF_LEN_FMT24 6'h18
`define ADCF_LEN_FMT32 6'h20

`endif

// *** rtl/adcf_pkg.sv ***
// Types shared by the converter serial frame and alarm block
package adcf_pkg;
  typedef enum logic [1:0] {ADCF_IDLE = 2'b00, ADCF_CONV = 2'b01, ADCF_DONE = 2'b11} adcf_conv_st_t;
  typedef enum logic [1:0] {ADCF_FMT_16 = 2'b00, ADCF_FMT_24 = 2'b01, ADCF_FMT_32 = 2'b10} adcf_fmt_t;
endpackage

// *** rtl/adcf_sync.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module adcf_sync import adcf_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;

  // ==========================================================
  // First stage feeds the second stage only
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// *** rtl/adcf_alarm.sv ***
// Per-channel high and low alarm with hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "adcf_params.svh"
module adcf_alarm import adcf_pkg::*;
#(
  parameter int CW = `ADCF_CODE_BITS,
  parameter int HW = `ADCF_HYS_BITS
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic eval_i,
  input wire logic [CW-1:0] code_i,
  input wire logic [CW-1:0] hi_thr_i,
  input wire logic [HW-1:0] hi_hys_i,
  input wire logic [CW-1:0] lo_thr_i,
  input wire logic [HW-1:0] lo_hys_i,
  input wire logic trip_rd_i,
  output logic hi_act_o,
  output logic lo_act_o,
  output logic hi_trip_o,
  output logic lo_trip_o
);
  logic signed [CW+2:0] code_x;
  logic signed [CW+2:0] hi_top;
  logic signed [CW+2:0] hi_bot;
  logic signed [CW+2:0] lo_bot;
  logic signed [CW+2:0] lo_top;
  logic hi_set;
  logic hi_clr;
  logic lo_set;
  logic lo_clr;

  // ==========================================================
  // Elaboration checks
  // Hysteresis is zero-extended into the code width, so it may not be wider
  generate
    if (HW < 1 || HW > CW)
    begin : g_bad_hw
      $error("hysteresis width must be 1 to code width");
    end
  endgenerate

  // ==========================================================
  // Limits held wide and signed so none of them wraps
  assign code_x = $signed({3'b000, code_i});
  assign hi_top = $signed({3'b000, hi_thr_i}) + $signed({{(CW-HW+3){1'b0}}, hi_hys_i});
  assign hi_bot = $signed({3'b000, hi_thr_i}) - $signed({{(CW-HW+3){1'b0}}, hi_hys_i})
    - $signed((CW+3)'(`ADCF_HI_CLR_OFS));
  assign lo_bot = $signed({3'b000, lo_thr_i}) - $signed({{(CW-HW+3){1'b0}}, lo_hys_i})
    - $signed((CW+3)'(`ADCF_LO_SET_OFS));
  assign lo_top = $signed({3'b000, lo_thr_i}) + $signed({{(CW-HW+3){1'b0}}, lo_hys_i})
    + $signed((CW+3)'(`ADCF_LO_CLR_OFS));
  assign hi_set = eval_i && (code_x > hi_top);
  assign hi_clr = eval_i && (code_x <= hi_bot);
  assign lo_set = eval_i && (code_x < lo_bot);
  assign lo_clr = eval_i && (code_x >= lo_top);

  // ==========================================================
  // Active flags follow the condition
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      hi_act_o <= 1'b0;
      lo_act_o <= 1'b0;
    end
    else
    begin
      if (hi_set)
        hi_act_o <= 1'b1;
      else if (hi_clr)
        hi_act_o <= 1'b0;
      if (lo_set)
        lo_act_o <= 1'b1;
      else if (lo_clr)
        lo_act_o <= 1'b0;
    end
  end

  // ==========================================================
  // Tripped flags latch; a new trip beats a read in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      hi_trip_o <= 1'b0;
      lo_trip_o <= 1'b0;
    end
    else
    begin
      hi_trip_o <= hi_set || (hi_trip_o && !trip_rd_i);
      lo_trip_o <= lo_set || (lo_trip_o && !trip_rd_i);
    end
  end

  // ==========================================================
  // Checks
  chk_hi_set_both: assert property (@(posedge clk_i) disable iff (srst_i)
    eval_i && code_x > hi_top |=> hi_act_o && hi_trip_o)
    else $error("high alarm did not set");
  chk_hi_clear_act: assert property (@(posedge clk_i) disable iff (srst_i)
    eval_i && code_x <= hi_bot |=> !hi_act_o)
    else $error("high alarm did not clear");
  chk_lo_set_both: assert property (@(posedge clk_i) disable iff (srst_i)
    eval_i && code_x < lo_bot |=> lo_act_o && lo_trip_o)
    else $error("low alarm did not set");
  chk_lo_clear_act: assert property (@(posedge clk_i) disable iff (srst_i)
    eval_i && code_x >= lo_top && !(code_x < lo_bot) |=> !lo_act_o)
    else $error("low alarm did not clear");
  chk_trip_latch_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    hi_trip_o && !trip_rd_i && !hi_clr ##1 !trip_rd_i |-> hi_trip_o ##0 $stable(hi_trip_o))
    else $error("tripped flag lost without read");
endmodule
`default_nettype wire

// *** sim/adcf_host_model.sv ***
// Host controller model that drives chip select, serial clock and serial data
`timescale 1ns/1ps
`default_nettype none
module adcf_host_model
#(
  parameter int HALF = 6,
  parameter int CONV_WAIT = 20
)
(
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  // ==========================================================
  // Idle levels; the serial clock stands still between frames
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    sdi_o = 1'b0;
  end

  // ==========================================================
  // One frame: config word in, len output bits back
  task automatic frame(input logic [15:0] cfg, input int len, output logic [31:0] rx,
                       output logic ok);
    int k;
    rx = '0;
    ok = 1'b1;
    // Stay off the system clock edges so the select never moves as it is sampled
    #1;
    cs_n_o = 1'b0;
    #(HALF);
    for (k = 1; k <= len + 18; k++)
    begin
      // Toggle after the word so that late capture would corrupt the config
      sdi_o = (k <= 16) ? cfg[16 - k] : ~sdi_o;
      if (k == 16)
        #(CONV_WAIT);
      #(HALF);
      if (k >= 17 && k <= 16 + len)
        rx[48 - k] = sdo_i;
      else if (sdo_i !== 1'b0)
        ok = 1'b0;
      if (sdo_oe_i !== 1'b1)
        ok = 1'b0;
      sclk_o = 1'b0;
      #(HALF);
      sclk_o = 1'b1;
    end
    #(HALF);
    cs_n_o = 1'b1;
    #(HALF);
    if (sdo_oe_i !== 1'b0)
      ok = 1'b0;
    sdi_o = ~sdi_o;
    #(40);
  endtask
endmodule
`default_nettype wire

// *** sim/adcf_frame_tb_top.sv ***
// Testbench of the converter serial frame and alarm block
`timescale 1ns/1ps
`default_nettype none
module adcf_frame_tb_top;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe, alarm, conv_start, busy;
  logic conv_done = 1'b0;
  logic [1:0] out_fmt = 2'b00;
  logic [2:0] conv_chan, seen_chan;
  logic [15:0] conv_code = 16'h0000;
  logic [15:0] result, cfg_word, cur_code;
  logic [127:0] hi_thr, lo_thr;
  logic [63:0] hi_hys, lo_hys;
  logic [7:0] trip_rd = 8'h00;
  logic [7:0] hi_act, lo_act, hi_trip, lo_trip;
  int wait_cnt = 0;
  int starts = 0;
  int busy_hits = 0;
  logic [7:0] tprev = 8'h00;
  int fails = 0;
  int num_checks = 0;
  // Codes walk channel 2 across both alarm edges; flags {rd,hi_act,hi_trip,lo_act,lo_trip}
  logic [15:0] codes [9] = '{16'h8010, 16'h8011, 16'h7FEF, 16'h7FEE, 16'h0FF7, 16'h0FF6,
                             16'h1008, 16'h1009, 16'h1234};
  logic [4:0] expf [9] = '{5'h00, 5'h0C, 5'h0C, 5'h14, 5'h00, 5'h03, 5'h03, 5'h11, 5'h00};

  always #2 sys_clk_i = ~sys_clk_i;

  adcf_frame #(.NCH(8)) dut_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .alarm_o(alarm), .out_fmt_i(out_fmt),
    .conv_start_o(conv_start), .conv_chan_o(conv_chan), .conv_code_i(conv_code),
    .conv_done_i(conv_done), .busy_o(busy), .result_o(result), .cfg_word_o(cfg_word),
    .hi_thr_i(hi_thr), .hi_hys_i(hi_hys), .lo_thr_i(lo_thr), .lo_hys_i(lo_hys),
    .trip_rd_i(trip_rd), .hi_act_o(hi_act), .lo_act_o(lo_act), .hi_trip_o(hi_trip),
    .lo_trip_o(lo_trip)
  );

  adcf_host_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo),
                          .sdo_oe_i(sdo_oe));

  // ==========================================================
  // Converter core stand-in; code bus shows garbage when not valid
  always @(posedge sys_clk_i)
  begin
    conv_done <= 1'b0;
    conv_code <= ~cur_code;
    if (conv_start)
    begin
      wait_cnt <= 6;
      seen_chan <= conv_chan;
      starts <= starts + 1;
      busy_hits <= busy_hits + ((busy === 1'b1) ? 1 : 0);
    end
    else if (wait_cnt == 1)
    begin
      wait_cnt <= 0;
      conv_done <= 1'b1;
      conv_code <= cur_code;
    end
    else if (wait_cnt > 1)
      wait_cnt <= wait_cnt - 1;
  end

  // ==========================================================
  // Comparison, verdict and frame tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic step(input logic [15:0] cfg, input logic [2:0] conv_ch,
                      input logic [15:0] code, input logic [1:0] fmt, input logic [7:0] trip);
    logic [31:0] rx, mask;
    logic ok;
    int len;
    len = (fmt == 2'b00) ? 16 : (fmt == 2'b01) ? 24 : 32;
    // Tripped byte holds the flags as they stood before this result was judged
    mask = (fmt == 2'b00) ? 32'hFFFF0000 : (fmt == 2'b01) ? 32'hFFFFFF00 : 32'hFFFFFFFF;
    cur_code = code;
    @(posedge sys_clk_i);
    out_fmt <= fmt;
    @(posedge sys_clk_i);
    host_u.frame(cfg, len, rx, ok);
    repeat (4) @(posedge sys_clk_i);
    check("sdo_word", rx & mask, {code, 5'b00000, conv_ch, trip} & mask);
    check("busy_end", 32'(busy), 32'h0);
    check("sdo_low", 32'(ok), 32'h1);
    check("conv_chan", 32'(seen_chan), 32'(conv_ch));
    check("result", 32'(result), 32'(code));
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      hi_thr[16*i +: 16] = (i == 2) ? 16'h8000 : 16'hFFFF;
      lo_thr[16*i +: 16] = (i == 2) ? 16'h1000 : 16'h0000;
      hi_hys[8*i +: 8] = (i == 2) ? 8'h10 : 8'h00;
      lo_hys[8*i +: 8] = (i == 2) ? 8'h08 : 8'h00;
    end
    cur_code = 16'h0000;
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    check("reset_alarm", 32'(alarm), 32'h0);
    check("idle_oe", 32'(sdo_oe), 32'h0);
    step(16'h8200, 3'd0, 16'hA5C3, 2'b11, 8'h00);
    check("cfg_held", 32'(cfg_word), 32'h0);
    check("other_chan", 32'(hi_act | lo_act), 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      step(16'h8200, 3'd2, codes[i], 2'(i % 3), tprev);
      check("hi_act", 32'(hi_act[2]), 32'(expf[i][3]));
      check("hi_trip", 32'(hi_trip[2]), 32'(expf[i][2]));
      check("lo_act", 32'(lo_act[2]), 32'(expf[i][1]));
      check("lo_trip", 32'(lo_trip[2]), 32'(expf[i][0]));
      check("alarm", 32'(alarm), 32'(expf[i][2] | expf[i][0]));
      if (expf[i][4])
      begin
        @(posedge sys_clk_i);
        trip_rd <= 8'h04;
        @(posedge sys_clk_i);
        trip_rd <= 8'h00;
        repeat (3) @(posedge sys_clk_i);
        check("trip_clear", 32'(hi_trip | lo_trip), 32'h0);
        check("alarm_hold", 32'(alarm), 32'h1);
      end
      tprev = expf[i][4] ? 8'h00 : {5'b00000, expf[i][2] | expf[i][0], 2'b00};
    end
    // A word without the select bit must leave the channel alone
    step(16'h0500, 3'd2, 16'h4000, 2'b00, tprev);
    check("cfg_applied", 32'(cfg_word), 32'h8200);
    step(16'h8200, 3'd2, 16'h4000, 2'b00, 8'h00);
    check("cfg_kept", 32'(cfg_word), 32'h0500);
    check("starts", 32'(starts), 32'd12);
    check("busy_start", 32'(busy_hits), 32'd12);
    summarize();
  end

  // ==========================================================
  // Watchdog; twelve frames need well under ten microseconds
  initial
  begin
    #(50000);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
